// ===== rtl/ecfd_defines.vh
`ifndef ECFD_DEFINES_VH
`define ECFD_DEFINES_VH

// register byte offsets
`define ECFD_OFS_ENABLE 8'h00
`define ECFD_OFS_TRIG 8'h04
`define ECFD_OFS_MODE 8'h08
`define ECFD_OFS_RELOAD 8'h0C
`define ECFD_OFS_COUNT 8'h10
`define ECFD_OFS_STATUS 8'h14
`define ECFD_OFS_OUTPUT 8'h18
`define ECFD_OFS_CHSTAT 8'h1C

// unit enable register
`define ECFD_EN_BIT 0

// trigger register
`define ECFD_TRIG_START 0
`define ECFD_TRIG_STOP 1

// mode register fields
`define ECFD_MODE_SEL 0
`define ECFD_MODE_EDGE_LO 1
`define ECFD_MODE_EDGE_HI 2
`define ECFD_MODE_STINT 3
`define ECFD_MODE_NFEN 4
`define ECFD_MODE_W 5

// mode select values
`define ECFD_MODE_EVENT 1'b0
`define ECFD_MODE_DIVIDE 1'b1

// edge select values
`define ECFD_EDGE_FALL 2'h0
`define ECFD_EDGE_RISE 2'h1
`define ECFD_EDGE_BOTH 2'h2

// status register fields
`define ECFD_STAT_ACTIVE 0
`define ECFD_STAT_PIN 1
`define ECFD_STAT_WAIT 2

// output control register fields
`define ECFD_OUT_LEVEL 0
`define ECFD_OUT_EN 1
`define ECFD_OUT_MODE 2
`define ECFD_OUT_POL 3
`define ECFD_OUT_W 4

// reset values
`define ECFD_RST_MODE 5'h00
`define ECFD_RST_RELOAD 16'h0000
`define ECFD_RST_COUNT 16'h0000
`define ECFD_RST_OUTPUT 4'h0
`define ECFD_ZERO16 16'h0000

`endif

// ===== rtl/ecfd_event_counter.v
// Overview of operation
// - event mode interrupts after reload plus one edges
// - count register counts down in event mode
// - start trigger copies reload value into count in event mode
// - each valid input edge decrements the count
// - at zero reload, interrupt, and keep repeating
// - reload writes apply from the next period
// - start sets active flag and awaits edges
// - count always readable; status register shows active, pin and wait
// - stop clears active, freezes count; triggers self-clear
// - unit disabled ignores writes except to the enable register, initializes everything
// - divider mode only on unit 0 channel 0
// - single edge divides by two times reload plus one
// - divider loads count on first valid edge
// - start interrupt select gates first load toggle
// - divider toggles output and interrupts at zero
// - both edges pass input duty error through
// - input sampling adds one clock period error
// - stopping divider holds the output level
// - unit disable clears output, returns pin to port
// - noise filter needs two stable synchronized samples
`timescale 1ns/1ns
`default_nettype none
`include "ecfd_defines.vh"

module ecfd_event_counter #(
    parameter CNT_W = 16,
    parameter DIVIDER_CAPABLE = 1
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // timer pins
    input wire event_input_pin_i,
    output reg waveform_output_pin_o,
    output wire waveform_output_oe_o,
    // event
    output reg channel_interrupt_o
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_WAIT = 3'b010;
    localparam [2:0] ST_RUN = 3'b100;

    // software state
    reg unit_clock_enable;
    reg [`ECFD_MODE_W-1:0] channel_mode_register;
    reg [CNT_W-1:0] reload_value_register;
    reg [CNT_W-1:0] channel_count_register;
    reg [`ECFD_OUT_W-1:0] output_ctrl;
    reg [2:0] state;
    reg channel_active_flag;

    // input path
    reg pin_sync1;
    reg pin_sync2;
    reg pin_hold;
    reg pin_filt;
    reg pin_filt_d;

    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
    wire wr_ok = bus_wr & unit_clock_enable;

    wire wr_en = bus_wr && (wb_adr_i == `ECFD_OFS_ENABLE);
    wire wr_trig = wr_ok && (wb_adr_i == `ECFD_OFS_TRIG);
    wire wr_mode = wr_ok && (wb_adr_i == `ECFD_OFS_MODE);
    wire wr_reload = wr_ok && (wb_adr_i == `ECFD_OFS_RELOAD);
    wire wr_out = wr_ok && (wb_adr_i == `ECFD_OFS_OUTPUT);

    wire start_trig = wr_trig & wb_dat_i[`ECFD_TRIG_START];
    wire stop_trig = wr_trig & wb_dat_i[`ECFD_TRIG_STOP];

    wire div_mode = (channel_mode_register[`ECFD_MODE_SEL] == `ECFD_MODE_DIVIDE);
    wire [1:0] edge_sel = channel_mode_register[`ECFD_MODE_EDGE_HI:`ECFD_MODE_EDGE_LO];
    wire nf_en = channel_mode_register[`ECFD_MODE_NFEN];
    wire start_int_sel = channel_mode_register[`ECFD_MODE_STINT];
    wire out_en = output_ctrl[`ECFD_OUT_EN];

    // valid edge of the filtered input
    wire rise = pin_filt & ~pin_filt_d;
    wire fall = ~pin_filt & pin_filt_d;
    reg valid_edge;

    always @* begin
        if (edge_sel == `ECFD_EDGE_RISE) begin
            valid_edge = rise;
        end else if (edge_sel == `ECFD_EDGE_BOTH) begin
            valid_edge = rise | fall;
        end else begin
            valid_edge = fall;
        end
    end

    // synchronizer and noise filter, one clock domain
    always @(posedge clk_i) begin
        if (rst_i || !unit_clock_enable) begin
            pin_sync1 <= 1'b0;
            pin_sync2 <= 1'b0;
            pin_hold <= 1'b0;
            pin_filt <= 1'b0;
            pin_filt_d <= 1'b0;
        end else begin
            pin_sync1 <= event_input_pin_i;
            pin_sync2 <= pin_sync1;
            pin_hold <= pin_sync2;
            if (!nf_en || (pin_sync2 == pin_hold)) begin
                pin_filt <= pin_sync2;
            end
            pin_filt_d <= pin_filt;
        end
    end

    // unit enable; clearing it initializes the whole channel
    always @(posedge clk_i) begin
        if (rst_i) begin
            unit_clock_enable <= 1'b0;
        end else if (wr_en) begin
            unit_clock_enable <= wb_dat_i[`ECFD_EN_BIT];
        end
    end

    // software registers, written only while the unit is enabled
    always @(posedge clk_i) begin
        if (rst_i || !unit_clock_enable) begin
            channel_mode_register <= `ECFD_RST_MODE;
            reload_value_register <= `ECFD_RST_RELOAD;
        end else begin
            if (wr_mode) begin
                channel_mode_register <= wb_dat_i[`ECFD_MODE_W-1:0];
                if (DIVIDER_CAPABLE == 0) begin
                    channel_mode_register[`ECFD_MODE_SEL] <= `ECFD_MODE_EVENT;
                end
            end
            if (wr_reload) begin
                reload_value_register <= wb_dat_i[CNT_W-1:0];
            end
        end
    end

    // channel sequencer
    always @(posedge clk_i) begin
        if (rst_i || !unit_clock_enable) begin
            state <= ST_IDLE;
            channel_active_flag <= 1'b0;
            channel_count_register <= `ECFD_RST_COUNT;
            channel_interrupt_o <= 1'b0;
        end else begin
            channel_interrupt_o <= 1'b0;
            if (stop_trig) begin
                state <= ST_IDLE;
                channel_active_flag <= 1'b0;
            end else if (start_trig) begin
                channel_active_flag <= 1'b1;
                if (div_mode) begin
                    state <= ST_WAIT;
                end else begin
                    state <= ST_RUN;
                    channel_count_register <= reload_value_register;
                end
            end else begin
                case (state)
                    ST_WAIT: begin
                        if (valid_edge) begin
                            channel_count_register <= reload_value_register;
                            channel_interrupt_o <= start_int_sel;
                            state <= ST_RUN;
                        end
                    end
                    ST_RUN: begin
                        if (valid_edge) begin
                            if (channel_count_register == `ECFD_ZERO16) begin
                                channel_count_register <= reload_value_register;
                                channel_interrupt_o <= 1'b1;
                            end else begin
                                channel_count_register <= channel_count_register - 1'b1;
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // output bit: toggles on each interrupt event while output enabled and not written that cycle, held when stopped
    wire first_toggle = (state == ST_WAIT) & valid_edge & start_int_sel & ~start_trig
        & ~stop_trig;
    wire zero_toggle = (state == ST_RUN) & valid_edge & ~start_trig & ~stop_trig
        & (channel_count_register == `ECFD_ZERO16);

    always @(posedge clk_i) begin
        if (rst_i || !unit_clock_enable) begin
            output_ctrl <= `ECFD_RST_OUTPUT;
            waveform_output_pin_o <= 1'b0;
        end else begin
            if (wr_out) begin
                output_ctrl <= wb_dat_i[`ECFD_OUT_W-1:0];
            end else if (out_en && (first_toggle || zero_toggle)) begin
                output_ctrl[`ECFD_OUT_LEVEL] <= ~output_ctrl[`ECFD_OUT_LEVEL];
            end
            waveform_output_pin_o <= output_ctrl[`ECFD_OUT_LEVEL];
        end
    end

    // pin driven only while enabled; otherwise it belongs to the port
    assign waveform_output_oe_o = unit_clock_enable & out_en;

    // wishbone: ack one cycle after request, unmapped reads zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h00000000;
            if (bus_req && !wb_we_i) begin
                if (wb_adr_i == `ECFD_OFS_ENABLE) begin
                    wb_dat_o[`ECFD_EN_BIT] <= unit_clock_enable;
                end else if (wb_adr_i == `ECFD_OFS_MODE) begin
                    wb_dat_o[`ECFD_MODE_W-1:0] <= channel_mode_register;
                end else if (wb_adr_i == `ECFD_OFS_RELOAD) begin
                    wb_dat_o[CNT_W-1:0] <= reload_value_register;
                end else if (wb_adr_i == `ECFD_OFS_COUNT) begin
                    wb_dat_o[CNT_W-1:0] <= channel_count_register;
                end else if (wb_adr_i == `ECFD_OFS_STATUS) begin
                    wb_dat_o[`ECFD_STAT_ACTIVE] <= channel_active_flag;
                    wb_dat_o[`ECFD_STAT_PIN] <= pin_filt;
                    wb_dat_o[`ECFD_STAT_WAIT] <= (state == ST_WAIT);
                end else if (wb_adr_i == `ECFD_OFS_OUTPUT) begin
                    wb_dat_o[`ECFD_OUT_W-1:0] <= output_ctrl;
                end
            end
        end
    end

endmodule // ecfd_event_counter
`default_nettype wire

// ===== bench/ecfd_mon_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module ecfd_mon (
    // bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // pins
    input wire logic waveform_output_pin_o,
    input wire logic waveform_output_oe_o,
    input wire logic channel_interrupt_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_off; s_take ##0 (wb_we_i && wb_adr_i == 8'h00 && !wb_dat_i[0]); endsequence
    sequence s_zrd; s_take ##0 (!wb_we_i && (wb_adr_i == 8'h04 || wb_adr_i > 8'h1B)); endsequence
    sequence s_cleared; !waveform_output_oe_o ##2 !waveform_output_pin_o; endsequence
    sequence s_irq_on; channel_interrupt_o && waveform_output_oe_o && !wb_cyc_i; endsequence
    AST_ACK_NEXT: assert property (s_take |=> wb_ack_o) else $error("ack missing");
    AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    AST_ZERO_READ: assert property (s_zrd |=> wb_dat_o == 32'h0)
        else $error("reserved read not zero");
    AST_OFF_CLEARS: assert property (s_off |=> s_cleared)
        else $error("disable left pin driven");
    AST_OE_BY_BUS: assert property ($changed(waveform_output_oe_o) |-> wb_ack_o)
        else $error("enable moved without write");
    AST_IRQ_PULSE: assert property (channel_interrupt_o |=> !channel_interrupt_o)
        else $error("interrupt not a pulse");
    AST_IRQ_TOGGLES: assert property (s_irq_on |=> $changed(waveform_output_pin_o))
        else $error("no toggle on interrupt");
    AST_PIN_CAUSE: assert property ($changed(waveform_output_pin_o) |->
        $past(channel_interrupt_o) || $past(wb_ack_o) || $past(wb_ack_o, 2))
        else $error("pin moved alone");
endmodule // ecfd_mon
`default_nettype wire

// ===== bench/ecfd_src.sv
`timescale 1ns/1ns
`default_nettype none
module ecfd_src (
    // control
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [7:0] n_i,
    input wire logic [3:0] hp_i,
    // pin
    output logic pin_o = 1'b0,
    output logic busy_o = 1'b0
);
    // whole pulses, then a quiet tail so the last edge reaches the counter
    always @(posedge go_i) begin
        busy_o <= 1'b1;
        repeat (n_i) begin
            repeat (hp_i) @(posedge clk_i);
            pin_o <= 1'b1;
            repeat (hp_i) @(posedge clk_i);
            pin_o <= 1'b0;
        end
        repeat (12) @(posedge clk_i);
        busy_o <= 1'b0;
    end
endmodule // ecfd_src
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, go = 1'b0;
    logic ack, pin, oe, irq, ev, busy;
    logic [7:0] adr = 8'h00, n = 8'h00;
    logic [3:0] hp = 4'h3;
    logic [31:0] dat = 32'h0, rdat, q;
    int miscompares = 0, checks = 0, irqs = 0;
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) if (irq === 1'b1) irqs++;
    ecfd_event_counter u_ecfd_event_counter (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .event_input_pin_i(ev), .waveform_output_pin_o(pin),
        .waveform_output_oe_o(oe), .channel_interrupt_o(irq));
    ecfd_src u_ecfd_src (.clk_i(clk_i), .go_i(go), .n_i(n), .hp_i(hp), .pin_o(ev), .busy_o(busy));
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t = 0;
        {cyc, we, adr, dat} <= {1'b1, w, a, d};
        do @(posedge clk_i); while (ack !== 1'b1 && ++t < 20);
        q = rdat;
        if (t >= 20) miscompares++;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, q);
    endtask
    task automatic send(input logic [7:0] k, input logic [3:0] h);
        {n, hp, go} <= {k, h, 1'b1};
        @(posedge clk_i);
        go <= 1'b0;
        do @(posedge clk_i); while (busy === 1'b1);
    endtask
    task automatic t_event;
        wb(1'b1, 8'h00, 32'h1);
        wb(1'b1, 8'h08, 32'h12);
        wb(1'b1, 8'h0C, 32'h2);
        wb(1'b1, 8'h04, 32'h1);
        rd(8'h10, 32'h2);
        send(8'h2, 4'h9);
        rd(8'h10, 32'h0);
        wb(1'b1, 8'h0C, 32'h1);
        send(8'h1, 4'h3);
        chk("irqs", 32'h1, irqs);
        rd(8'h10, 32'h1);
        wb(1'b1, 8'h04, 32'h2);
        send(8'h1, 4'h3);
        rd(8'h10, 32'h1);
        $display("event counter done");
    endtask
    task automatic t_divider;
        wb(1'b1, 8'h08, 32'h3);
        wb(1'b1, 8'h18, 32'h2);
        wb(1'b1, 8'h04, 32'h1);
        rd(8'h14, 32'h5);
        send(8'h1, 4'h4);
        chk("irqs", 32'h1, irqs);
        send(8'h2, 4'h4);
        chk("irqs", 32'h2, irqs);
        wb(1'b1, 8'h04, 32'h2);
        chk("pin", 32'h1, {31'h0, pin});
        wb(1'b1, 8'h00, 32'h0);
        wb(1'b1, 8'h0C, 32'h7);
        chk("pin oe", 32'h0, {30'h0, pin, oe});
        rd(8'h0C, 32'h0);
        rd(8'h20, 32'h0);
        $display("divider and disable done");
    endtask
    task automatic give_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_event();
        t_divider();
        give_verdict();
    end
    initial #200000 begin
        miscompares++;
        give_verdict();
    end
endmodule // tb_top
bind ecfd_event_counter ecfd_mon u_ecfd_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .waveform_output_pin_o(waveform_output_pin_o),
    .waveform_output_oe_o(waveform_output_oe_o), .channel_interrupt_o(channel_interrupt_o));
`default_nettype wire
